/* logic/instr_exec_unit.sv */
// Execute unit for the add group through the unconditional jump.
// Assumes an Avalon-MM master on i_clk; data memory and stack live here.
//
// Register access over Avalon-MM and the address map were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module instr_exec_unit
    import exec_pkg::*;
#(
    parameter int STACK_DEPTH  = 16,
    parameter int DM_WORDS     = 16,
    parameter int WDT_PRESCALE = 256
) (
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic [7:0]  i_address,
    input  wire logic        i_read,
    input  wire logic        i_write,
    input  wire logic [31:0] i_writedata,
    input  wire logic [3:0]  i_byteenable,
    output var  logic        o_waitrequest,
    output var  logic [31:0] o_readdata,
    output var  logic        o_halted
);
    localparam int DAW = $clog2(DM_WORDS);
    localparam int SAW = $clog2(STACK_DEPTH);

    function automatic logic [31:0] merge_be(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] be);
        logic [31:0] m;
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        return (old & ~m) | (wd & m);
    endfunction : merge_be

    function automatic alu_t add8(input logic [7:0] a, input logic [7:0] b, input logic cin);
        logic [4:0] lo;
        logic [8:0] full;
        alu_t       r;
        lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
        r.res = full[7:0];
        r.c = full[8];
        r.h = lo[4];
        r.v = (a[7] == b[7]) && (full[7] != a[7]);
        return r;
    endfunction : add8

    function automatic logic [8:0] bcd_fix(input logic [7:0] a, input logic h, input logic c);
        logic [3:0] lo;
        logic       adj;
        logic [4:0] hs;
        logic [3:0] hi;
        logic       co;
        if (a[3:0] > BCD_LIMIT || h) begin
            lo = a[3:0] + BCD_ADJUST;
            adj = ~h;
        end else begin
            lo = a[3:0];
            adj = 1'b0;
        end
        hs = {1'b0, a[7:4]} + {4'h0, adj};
        if (hs > {1'b0, BCD_LIMIT} || c) begin
            hi = 4'(a[7:4] + BCD_ADJUST + {3'h0, adj});
            co = 1'b1;
        end else begin
            hi = hs[3:0];
            co = c;
        end
        return {co, hi, lo};
    endfunction : bcd_fix

    logic [7:0]     work_register;
    logic           carry;
    logic           half_carry_flag;
    logic           zero;
    logic           signed_wrap_flag;
    logic           sleep_entered_flag;
    logic           watchdog_expired_flag;
    logic [12:0]    pc;
    logic [12:0]    stack [STACK_DEPTH];
    logic [SAW-1:0] sp;
    logic [7:0]     dmem [DM_WORDS];
    cmd_t           cmd;
    logic [4:0]     busy_cnt;
    logic [7:0]     watchdog_counter;
    logic [15:0]    prescale;
    logic           pre_first;
    logic           pre_second;

    // Bus decode
    wire        done       = ~o_waitrequest;
    wire        wr_done    = done & i_write;
    wire        sel_cmd    = i_address == OFS_CMD;
    wire        sel_work   = i_address == OFS_WORK;
    wire        sel_status = i_address == OFS_STATUS;
    wire        sel_pc     = i_address == OFS_PC;
    wire        sel_stack  = i_address == OFS_STACK;
    wire        sel_wdog   = i_address == OFS_WDOG;
    wire [7:0]  dm_off     = i_address - OFS_DMEM;
    wire        sel_dm     = (i_address >= OFS_DMEM) && ({1'b0, dm_off} < 9'(4 * DM_WORDS))
                             && (i_address[1:0] == 2'b00);
    wire [DAW-1:0] dm_bus_idx = dm_off[DAW+1:2];
    wire        busy       = busy_cnt != 5'h00;
    wire        cmd_blocked = i_write & sel_cmd & busy;
    wire        next_ack   = (i_read | i_write) & o_waitrequest & ~cmd_blocked;
    wire [31:0] wmerge_status = merge_be(32'h0000_0000, i_writedata, i_byteenable);
    wire        status_wr  = wr_done & sel_status & i_byteenable[0];
    wire [31:0] status_word = {24'h000000, o_halted, busy, watchdog_expired_flag, sleep_entered_flag,
                               signed_wrap_flag, zero, half_carry_flag, carry};
    wire [31:0] rd_mux =
        sel_cmd    ? 32'(cmd) :
        sel_work   ? {24'h000000, work_register} :
        sel_status ? status_word :
        sel_pc     ? {19'h00000, pc} :
        sel_stack  ? 32'(sp) :
        sel_wdog   ? {24'h000000, watchdog_counter} :
        sel_dm     ? {24'h000000, dmem[dm_bus_idx]} : 32'h0000_0000;

    // Instruction issue
    wire cmd_t     new_cmd = cmd_t'(merge_be(32'(cmd), i_writedata, i_byteenable));
    wire           go      = wr_done & sel_cmd & ~o_halted;
    wire [DAW-1:0] m_idx   = new_cmd.operand[DAW-1:0];
    wire [7:0]     dm_rd   = dmem[m_idx];
    wire alu_t     s_adc   = add8(work_register, dm_rd, carry);
    wire alu_t     s_add   = add8(work_register, dm_rd, 1'b0);
    wire alu_t     s_addi  = add8(work_register, new_cmd.operand, 1'b0);
    wire [8:0]     s_bcd   = bcd_fix(work_register, half_carry_flag, carry);

    logic [7:0]  next_work;
    logic [7:0]  next_mem;
    logic        mem_we;
    logic        next_c;
    logic        next_h;
    logic        next_z;
    logic        next_v;
    logic [12:0] next_pc;
    logic        push;
    logic        wdt_clr;
    logic        flag_clr;
    logic        enter_sleep;
    logic        next_first;
    logic        next_second;
    int          cycles;
    alu_t        sum;

    always_comb begin
        next_work = work_register;
        next_mem = dm_rd;
        mem_we = 1'b0;
        next_c = carry;
        next_h = half_carry_flag;
        next_z = zero;
        next_v = signed_wrap_flag;
        next_pc = 13'(pc + 13'h0001);
        push = 1'b0;
        wdt_clr = 1'b0;
        flag_clr = 1'b0;
        enter_sleep = 1'b0;
        next_first = pre_first;
        next_second = pre_second;
        cycles = BASE_CYCLES;
        sum = s_add;
        case (new_cmd.op)
            add_with_carry_op, add_with_carry_to_memory_op: begin
                sum = s_adc;
            end
            add_immediate_op: begin
                sum = s_addi;
            end
            default: begin
                sum = s_add;
            end
        endcase
        case (new_cmd.op)
            add_with_carry_op, add_op, add_immediate_op: begin
                next_work = sum.res;
                {next_c, next_h, next_v} = {sum.c, sum.h, sum.v};
                next_z = sum.res == 8'h00;
            end
            add_with_carry_to_memory_op, add_to_memory_op: begin
                next_mem = sum.res;
                mem_we = 1'b1;
                {next_c, next_h, next_v} = {sum.c, sum.h, sum.v};
                next_z = sum.res == 8'h00;
            end
            bitwise_and_op: begin
                next_work = work_register & dm_rd;
                next_z = next_work == 8'h00;
            end
            bitwise_and_immediate_op: begin
                next_work = work_register & new_cmd.operand;
                next_z = next_work == 8'h00;
            end
            bitwise_and_to_memory_op: begin
                next_mem = work_register & dm_rd;
                mem_we = 1'b1;
                next_z = next_mem == 8'h00;
            end
            call_op: begin
                push = 1'b1;
                next_pc = new_cmd.target;
                cycles = BRANCH_CYCLES;
            end
            clear_byte_op: begin
                next_mem = 8'h00;
                mem_we = 1'b1;
            end
            clear_bit_op: begin
                next_mem = dm_rd & ~(8'h01 << new_cmd.bit_sel);
                mem_we = 1'b1;
            end
            watchdog_clear_op: begin
                wdt_clr = 1'b1;
                flag_clr = 1'b1;
            end
            watchdog_preclear_first_op, watchdog_preclear_second_op: begin
                if (new_cmd.op == watchdog_preclear_first_op ? pre_second : pre_first) begin
                    wdt_clr = 1'b1;
                    flag_clr = 1'b1;
                    next_first = 1'b0;
                    next_second = 1'b0;
                end else if (new_cmd.op == watchdog_preclear_first_op) begin
                    next_first = 1'b1;
                end else begin
                    next_second = 1'b1;
                end
            end
            invert_byte_op: begin
                next_mem = ~dm_rd;
                mem_we = 1'b1;
                next_z = next_mem == 8'h00;
            end
            invert_byte_to_register_op: begin
                next_work = ~dm_rd;
                next_z = next_work == 8'h00;
            end
            decimal_adjust_op: begin
                next_mem = s_bcd[7:0];
                mem_we = 1'b1;
                next_c = s_bcd[8];
            end
            decrement_op: begin
                next_mem = 8'(dm_rd - 8'h01);
                mem_we = 1'b1;
                next_z = next_mem == 8'h00;
            end
            decrement_to_register_op: begin
                next_work = 8'(dm_rd - 8'h01);
                next_z = next_work == 8'h00;
            end
            increment_op: begin
                next_mem = 8'(dm_rd + 8'h01);
                mem_we = 1'b1;
                next_z = next_mem == 8'h00;
            end
            increment_to_register_op: begin
                next_work = 8'(dm_rd + 8'h01);
                next_z = next_work == 8'h00;
            end
            power_down_op: begin
                enter_sleep = 1'b1;
                wdt_clr = 1'b1;
            end
            jump_op: begin
                next_pc = new_cmd.target;
                cycles = BRANCH_CYCLES;
            end
            default: begin
                next_work = work_register;
            end
        endcase
        if (mem_we && m_idx == DAW'(PCL_ADDR)) begin
            next_pc = {pc[12:8], next_mem};
            cycles = cycles + 1;
        end
    end

    // Watchdog prescaler and counter
    wire tick     = prescale == 16'(WDT_PRESCALE - 1);
    wire wdt_ovf  = tick & (watchdog_counter == 8'hff);
    wire wdt_zero = go & wdt_clr;

    always_ff @(posedge i_clk) begin
        if (i_rst || wdt_zero) begin
            prescale <= 16'h0000;
            watchdog_counter <= 8'h00;
        end else begin
            prescale <= tick ? 16'h0000 : 16'(prescale + 16'h0001);
            watchdog_counter <= tick ? 8'(watchdog_counter + 8'h01) : watchdog_counter;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            watchdog_expired_flag <= 1'b0;
            sleep_entered_flag <= 1'b0;
            o_halted <= 1'b0;
        end else begin
            if (wdt_ovf) begin
                watchdog_expired_flag <= 1'b1;
            end else if (go && (flag_clr || enter_sleep)) begin
                watchdog_expired_flag <= 1'b0;
            end
            if (go && enter_sleep) begin
                sleep_entered_flag <= 1'b1;
            end else if (go && flag_clr) begin
                sleep_entered_flag <= 1'b0;
            end
            if (go && enter_sleep) begin
                o_halted <= 1'b1;
            end else if (wdt_ovf || (status_wr && !wmerge_status[ST_HALTED])) begin
                o_halted <= 1'b0;
            end
        end
    end

    // Architectural state
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            work_register <= RST_WORK;
            {carry, half_carry_flag, zero, signed_wrap_flag} <= 4'h0;
            pc <= RST_PC;
            sp <= '0;
            cmd <= cmd_t'(RST_CMD);
            pre_first <= 1'b0;
            pre_second <= 1'b0;
        end else if (go) begin
            work_register <= next_work;
            {carry, half_carry_flag, zero, signed_wrap_flag} <= {next_c, next_h, next_z, next_v};
            pc <= next_pc;
            sp <= push ? SAW'(sp + 1'b1) : sp;
            cmd <= new_cmd;
            pre_first <= next_first;
            pre_second <= next_second;
        end else begin
            if (wr_done && sel_work && i_byteenable[0]) begin
                work_register <= i_writedata[7:0];
            end
            if (status_wr) begin
                {signed_wrap_flag, zero, half_carry_flag, carry} <= wmerge_status[ST_WRAP:ST_CARRY];
            end
            if (wr_done && sel_pc) begin
                pc <= 13'(merge_be({19'h00000, pc}, i_writedata, i_byteenable));
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (go && push) begin
            stack[sp] <= 13'(pc + 13'h0001);
        end
        if (go && mem_we) begin
            dmem[m_idx] <= next_mem;
        end else if (wr_done && sel_dm && i_byteenable[0]) begin
            dmem[dm_bus_idx] <= i_writedata[7:0];
        end
    end

    // Instruction timing and bus handshake
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            busy_cnt <= 5'h00;
            o_waitrequest <= 1'b1;
            o_readdata <= 32'h0000_0000;
        end else begin
            if (go) begin
                busy_cnt <= 5'(INSTR_CLKS * cycles - 1);
            end else if (busy) begin
                busy_cnt <= 5'(busy_cnt - 5'h01);
            end
            o_waitrequest <= ~next_ack;
            o_readdata <= next_ack ? rd_mux : o_readdata;
        end
    end

    // Checks
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    wire [7:0]  chk_adc   = 8'(work_register + dm_rd + {7'h00, carry});
    wire        op_adc    = go && new_cmd.op == add_with_carry_op;
    wire        op_add_to_memory_op   = go && new_cmd.op == add_to_memory_op;
    wire        op_and    = go && new_cmd.op == bitwise_and_op;
    wire        op_call   = go && new_cmd.op == call_op;
    wire        op_jump   = go && new_cmd.op == jump_op;
    wire        op_wclr   = go && new_cmd.op == watchdog_clear_op;
    wire        op_pre1   = go && new_cmd.op == watchdog_preclear_first_op;
    wire        op_halt   = go && new_cmd.op == power_down_op;
    wire        op_bcd    = go && new_cmd.op == decimal_adjust_op;
    wire        pcl_plain = go && mem_we && m_idx == DAW'(PCL_ADDR) && cycles == BASE_CYCLES + 1;
    wire [12:0] chk_tgt   = new_cmd.target;
    wire [12:0] stack_top = stack[SAW'(sp - 1'b1)];

    a_adc_work_sum: assert property (op_adc |=> work_register == $past(chk_adc))
        else $error("add with carry result wrong");
    a_add_to_memory_op_keeps_work: assert property (op_add_to_memory_op |=> $stable(work_register))
        else $error("memory add changed work register");
    a_and_flags_kept: assert property (op_and |=> $stable({carry, half_carry_flag, signed_wrap_flag}))
        else $error("and changed arithmetic flags");
    a_call_push_load: assert property (op_call |=> sp == SAW'($past(sp) + 1'b1) && pc == $past(chk_tgt)
                                       && stack_top == $past(13'(pc + 13'h0001)))
        else $error("call did not push and load");
    a_jump_no_stack: assert property (op_jump |=> $stable(sp) && pc == $past(chk_tgt))
        else $error("jump wrong target or stack");
    a_wdt_clear_all: assert property (op_wclr && !wdt_ovf |=> watchdog_counter == 8'h00 && !sleep_entered_flag)
        else $error("watchdog clear incomplete");
    a_preclear_single: assert property (op_pre1 && !pre_second |=> $stable(sleep_entered_flag) && pre_first)
        else $error("single preclear changed flags");
    a_halt_sleep_set: assert property (op_halt && !wdt_ovf |=> o_halted && sleep_entered_flag
                                       && !watchdog_expired_flag && watchdog_counter == 8'h00)
        else $error("power down flags wrong");
    a_bcd_flags_kept: assert property (op_bcd |=> $stable({zero, half_carry_flag, signed_wrap_flag}))
        else $error("decimal adjust changed other flags");
    a_pcl_extra_cycle: assert property (pcl_plain |=> busy [*7] ##1 !busy)
        else $error("pc low write cycle count wrong");
endmodule : instr_exec_unit
`default_nettype wire

/* common/exec_pkg.sv */
// Shared constants, opcodes and carriers for the instruction execute unit.
// Assumes a 32-bit Avalon-MM slave port with byte addresses.
package exec_pkg;
    localparam logic [7:0]  OFS_CMD      = 8'h00;
    localparam logic [7:0]  OFS_WORK     = 8'h04;
    localparam logic [7:0]  OFS_STATUS   = 8'h08;
    localparam logic [7:0]  OFS_PC       = 8'h0c;
    localparam logic [7:0]  OFS_STACK    = 8'h10;
    localparam logic [7:0]  OFS_WDOG     = 8'h14;
    localparam logic [7:0]  OFS_DMEM     = 8'h40;
    localparam int          ST_CARRY     = 0;
    localparam int          ST_HALF      = 1;
    localparam int          ST_ZERO      = 2;
    localparam int          ST_WRAP      = 3;
    localparam int          ST_SLEEP     = 4;
    localparam int          ST_EXPIRED   = 5;
    localparam int          ST_BUSY      = 6;
    localparam int          ST_HALTED    = 7;
    localparam logic [7:0]  PCL_ADDR     = 8'h02;
    localparam logic [3:0]  BCD_LIMIT    = 4'h9;
    localparam logic [3:0]  BCD_ADJUST   = 4'h6;
    localparam int          INSTR_CLKS   = 4;
    localparam int          BASE_CYCLES  = 1;
    localparam int          BRANCH_CYCLES = 2;
    localparam logic [7:0]  RST_WORK     = 8'h00;
    localparam logic [12:0] RST_PC       = 13'h0000;
    localparam logic [31:0] RST_CMD      = 32'h0000_0017;

    typedef enum logic [4:0] {
        add_with_carry_op = 5'b00000, add_with_carry_to_memory_op = 5'b00001, add_op = 5'b00010,
        add_immediate_op = 5'b00011, add_to_memory_op = 5'b00100, bitwise_and_op = 5'b00101,
        bitwise_and_immediate_op = 5'b00110, bitwise_and_to_memory_op = 5'b00111, call_op = 5'b01000,
        clear_byte_op = 5'b01001, clear_bit_op = 5'b01010, watchdog_clear_op = 5'b01011,
        watchdog_preclear_first_op = 5'b01100, watchdog_preclear_second_op = 5'b01101,
        invert_byte_op = 5'b01110, invert_byte_to_register_op = 5'b01111, decimal_adjust_op = 5'b10000,
        decrement_op = 5'b10001, decrement_to_register_op = 5'b10010, increment_op = 5'b10011,
        increment_to_register_op = 5'b10100, power_down_op = 5'b10101, jump_op = 5'b10110,
        no_op = 5'b10111
    } op_t;

    typedef struct packed {
        logic [2:0]  spare;
        logic [12:0] target;
        logic [7:0]  operand;
        logic [2:0]  bit_sel;
        op_t         op;
    } cmd_t;

    typedef struct packed {
        logic [7:0] res;
        logic       c;
        logic       h;
        logic       v;
    } alu_t;
endpackage : exec_pkg

/* tb/avm_host.sv */
// Avalon-MM master model for the execute unit's register port.
// Assumes the slave lowers waitrequest for one cycle to finish an access.
`timescale 1ns/1ns
`default_nettype none
module avm_host (
    input  wire logic        i_clk,
    input  wire logic        i_waitrequest,
    input  wire logic [31:0] i_readdata,
    output var  logic [7:0]  o_address,
    output var  logic        o_read,
    output var  logic        o_write,
    output var  logic [31:0] o_writedata,
    output var  logic [3:0]  o_byteenable
);
    initial begin
        o_address = 8'h00;
        o_read = 1'b0;
        o_write = 1'b0;
        o_writedata = 32'h0;
        o_byteenable = 4'h0;
    end

    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge i_clk);
        o_address    <= a;
        o_read       <= !w;
        o_write      <= w;
        o_writedata  <= d;
        o_byteenable <= 4'hf;
        do @(posedge i_clk); while (i_waitrequest !== 1'b0);
        q = i_readdata;
        o_read       <= 1'b0;
        o_write      <= 1'b0;
        o_writedata  <= ~d;
    endtask : xfer
endmodule : avm_host
`default_nettype wire

/* tb/mcu_instruction_execute_unit_tb.sv */
// Self-checking bench with a reference model of the execute unit.
// Assumes the register map and opcodes of the shared package.
`timescale 1ns/1ns
`default_nettype none
module mcu_instruction_execute_unit_tb;
    import exec_pkg::*;
    logic        i_clk, i_rst, rd_s, wr_s, waitreq, halted;
    logic [7:0]  adr, work, x;
    logic [31:0] wd, rdata, q;
    logic [3:0]  be, sp;
    logic [7:0]  mem [16];
    logic        c, h, z, v;
    logic [12:0] pc;
    logic [2:0]  b;
    op_t         op;
    int          n_errors, tests_run;

    instr_exec_unit #(.WDT_PRESCALE(4)) dut (.i_clk(i_clk), .i_rst(i_rst), .i_address(adr), .i_read(rd_s),
        .i_write(wr_s), .i_writedata(wd), .i_byteenable(be), .o_waitrequest(waitreq), .o_readdata(rdata),
        .o_halted(halted));
    avm_host host (.i_clk(i_clk), .i_waitrequest(waitreq), .i_readdata(rdata), .o_address(adr),
        .o_read(rd_s), .o_write(wr_s), .o_writedata(wd), .o_byteenable(be));

    initial begin
        i_clk = 1'b0;
        forever #2 i_clk = ~i_clk;
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        host.xfer(1'b1, a, d, q);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        host.xfer(1'b0, a, 32'h0, q);
    endtask : rd
    task automatic cmd(input op_t o, input logic [12:0] t, input logic [7:0] m, input logic [2:0] s);
        wr(OFS_CMD, {3'b000, t, m, s, o});
    endtask : cmd
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %0t got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic finish_test();
        $display("errors %0d checks %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : finish_test

    task automatic model();
        logic [8:0] s;
        logic [7:0] y, r;
        logic [4:0] hi;
        logic cin, wm, wa, nz, ar, a1;
        y = (op == add_immediate_op || op == bitwise_and_immediate_op) ? x : mem[x[3:0]];
        cin = (op == add_with_carry_op || op == add_with_carry_to_memory_op) & c;
        ar = op <= add_to_memory_op;
        s = work + y + cin;
        r = 8'h00;
        wm = 1'b0;
        wa = 1'b0;
        nz = 1'b1;
        case (op)
            add_with_carry_op, add_op, add_immediate_op: begin r = s[7:0]; wa = 1'b1; end
            add_with_carry_to_memory_op, add_to_memory_op: begin r = s[7:0]; wm = 1'b1; end
            bitwise_and_op, bitwise_and_immediate_op: begin r = work & y; wa = 1'b1; end
            bitwise_and_to_memory_op: begin r = work & y; wm = 1'b1; end
            clear_byte_op: begin wm = 1'b1; nz = 1'b0; end
            clear_bit_op: begin r = y & ~(8'h01 << b); wm = 1'b1; nz = 1'b0; end
            invert_byte_op: begin r = ~y; wm = 1'b1; end
            invert_byte_to_register_op: begin r = ~y; wa = 1'b1; end
            decrement_op: begin r = y - 8'h01; wm = 1'b1; end
            decrement_to_register_op: begin r = y - 8'h01; wa = 1'b1; end
            increment_op: begin r = y + 8'h01; wm = 1'b1; end
            increment_to_register_op: begin r = y + 8'h01; wa = 1'b1; end
            decimal_adjust_op: begin
                a1 = (work[3:0] > 4'h9 || h) ? !h : 1'b0;
                r[3:0] = (work[3:0] > 4'h9 || h) ? work[3:0] + 4'h6 : work[3:0];
                hi = work[7:4] + a1;
                r[7:4] = (hi > 5'h09 || c) ? 4'(hi + 5'h06) : hi[3:0];
                c = c | hi > 5'h09;
                wm = 1'b1;
                nz = 1'b0;
            end
            default: nz = 1'b0;
        endcase
        if (ar) begin
            h = ({1'b0, work[3:0]} + y[3:0] + cin) > 5'h0f;
            v = (({1'b0, work[6:0]} + y[6:0] + cin) > 8'h7f) ^ s[8];
            c = s[8];
        end
        if (nz) z = r == 8'h00;
        if (wa) work = r;
        if (wm) mem[x[3:0]] = r;
        if (wm && x[3:0] == 4'h2) pc[7:0] = r;
        else pc = pc + 13'h1;
    endtask : model

    initial begin
        n_errors = 0;
        tests_run = 0;
        i_rst = 1'b1;
        void'($urandom(32'hc7570099));
        repeat (6) @(posedge i_clk);
        i_rst <= 1'b0;
        for (int i = 0; i < 80; i++) begin
            do op = op_t'($urandom % 21); while (op inside {call_op, watchdog_clear_op,
                watchdog_preclear_first_op, watchdog_preclear_second_op});
            x = 8'($urandom);
            b = 3'($urandom);
            work = 8'($urandom);
            mem[x[3:0]] = 8'($urandom);
            {v, z, h, c} = 4'($urandom);
            pc = 13'($urandom);
            wr(OFS_WORK, 32'(work));
            wr(OFS_DMEM + {2'b00, x[3:0], 2'b00}, 32'(mem[x[3:0]]));
            wr(OFS_STATUS, 32'({v, z, h, c}));
            wr(OFS_PC, 32'(pc));
            cmd(op, 13'h0, x, b);
            model();
            rd(OFS_WORK);
            chk(q & 32'hff, 32'(work));
            rd(OFS_DMEM + {2'b00, x[3:0], 2'b00});
            chk(q & 32'hff, 32'(mem[x[3:0]]));
            rd(OFS_STATUS);
            chk(q & 32'h0f, 32'({v, z, h, c}));
            rd(OFS_PC);
            chk(q & 32'h1fff, 32'(pc));
        end
        rd(OFS_STACK);
        sp = q[3:0];
        pc = 13'($urandom);
        cmd(call_op, pc, 8'h00, 3'h0);
        rd(OFS_PC);
        chk(q & 32'h1fff, 32'(pc));
        rd(OFS_STACK);
        chk(q & 32'h0f, 32'(sp + 4'h1));
        pc = 13'($urandom);
        cmd(jump_op, pc, 8'h00, 3'h0);
        rd(OFS_PC);
        chk(q & 32'h1fff, 32'(pc));
        rd(OFS_STACK);
        chk(q & 32'h0f, 32'(sp + 4'h1));
        rd(OFS_STATUS);
        chk(q & 32'h0f, 32'({v, z, h, c}));
        repeat (1100) @(posedge i_clk);
        cmd(watchdog_preclear_first_op, 13'h0, 8'h00, 3'h0);
        rd(OFS_STATUS);
        chk(q & 32'h30, 32'h20);
        cmd(watchdog_preclear_second_op, 13'h0, 8'h00, 3'h0);
        rd(OFS_STATUS);
        chk(q & 32'h30, 32'h00);
        wr(OFS_DMEM + 8'h14, 32'h5a);
        cmd(power_down_op, 13'h0, 8'h00, 3'h0);
        rd(OFS_STATUS);
        chk(q & 32'hbf, 32'h90 | 32'({v, z, h, c}));
        chk(32'(halted), 32'h1);
        rd(OFS_WDOG);
        chk(32'(q < 32'h4), 32'h1);
        rd(OFS_PC);
        chk(q & 32'h1fff, 32'(pc + 13'h3));
        cmd(increment_op, 13'h0, 8'h05, 3'h0);
        rd(OFS_DMEM + 8'h14);
        chk(q & 32'hff, 32'h5a);
        wr(OFS_STATUS, 32'h0);
        @(posedge i_clk);
        chk(32'(halted), 32'h0);
        cmd(watchdog_clear_op, 13'h0, 8'h00, 3'h0);
        rd(OFS_STATUS);
        chk(q & 32'h3f, 32'h00);
        rd(OFS_WDOG);
        chk(32'(q < 32'h4), 32'h1);
        finish_test();
    end

    initial begin
        repeat (60000) @(posedge i_clk);
        n_errors++;
        finish_test();
    end
endmodule : mcu_instruction_execute_unit_tb
`default_nettype wire
